// [core/ddrps_fifo.sv]
// Parameterised valid/ready FIFO carrying captured read words
`timescale 1ns/1ps
module ddrps_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } ddrps_ptr_t;

    ddrps_ptr_t ptr_reg;
    ddrps_ptr_t ptr_next;
    logic [W-1:0] mem [DEPTH];
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////////
    // Full when pointers differ only in the wrap bit, empty when equal
    assign in_ready = !((ptr_reg.wr[AW] != ptr_reg.rd[AW])
                        && (ptr_reg.wr[AW-1:0] == ptr_reg.rd[AW-1:0]));
    assign out_valid = (ptr_reg.wr != ptr_reg.rd);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[ptr_reg.rd[AW-1:0]];

    // Pointer update
    always_comb
    begin
        ptr_next = ptr_reg;
        if (push)
        begin
            ptr_next.wr = ptr_reg.wr + 1'b1;
        end
        if (pop)
        begin
            ptr_next.rd = ptr_reg.rd + 1'b1;
        end
    end

    // Storage has no reset; only written slots are ever read
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[ptr_reg.wr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr_reg <= '0;
        end
        else
        begin
            ptr_reg <= ptr_next;
        end
    end
endmodule

// [core/ddrps_pkg.sv]
// Shared constants, state encodings and carrier types of the read strobe synchroniser
package ddrps_pkg;
    localparam int DQ_W = 8;
    localparam int FIFO_W = DQ_W + 1;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    localparam int EDGE_W = 4;
    // Strobe edges in one read burst, one data word per edge
    localparam logic [EDGE_W-1:0] BURST_EDGES = 4'h8;
    localparam logic [EDGE_W-1:0] EDGES_RST = 4'h0;
    localparam logic POL_RST = 1'b0;
    localparam logic PHASE_RST = 1'b0;
    // Level the termination holds the undriven strobe at
    localparam logic DQS_IDLE_LVL = 1'b1;
    localparam logic [DQ_W-1:0] DQ_RST = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_BURST = 4'b0100,
        ST_DRAIN = 4'b1000
    } ddrps_state_t;

    // One captured word with a marker on the final word of the burst
    typedef struct packed {
        logic last;
        logic [DQ_W-1:0] data;
    } ddrps_beat_t;

    localparam ddrps_beat_t BEAT_RST = '{last: 1'b0, data: DQ_RST};

    typedef struct packed {
        ddrps_state_t state;
        logic dqs_s1;
        logic dqs_s2;
        logic dqs_s3;
        logic [DQ_W-1:0] dq_s1;
        logic [DQ_W-1:0] dq_s2;
        logic seen_idle;
        logic phase;
        logic pol;
        logic [EDGE_W-1:0] edges;
        logic pend;
        ddrps_beat_t hold;
        logic ovf;
    } ddrps_core_t;
endpackage

// [core/ddrps_sync.sv]
// Read capture from the delayed strobe domain with per-read clock polarity choice
`timescale 1ns/1ps
// Behaviour
// R1: Move strobe-captured data into system clock domain.
// R2: Polarity picks which system edge loads data.
// R3: Polarity chosen afresh at every read start.
// R4: Memory leaves strobe undriven before a read.
// R5: Memory drives strobe low at preamble start.
// R6: Detect idle-to-low strobe transition at preamble.
// R7: Detector output sets the synchroniser polarity.
// R8: Polarity held until burst data transferred.
module ddrps_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd_start,
    input wire logic dqs_in,
    input wire logic [ddrps_pkg::DQ_W-1:0] dq_in,
    output logic rd_busy,
    output logic pol_out,
    output logic overflow,
    output logic rd_valid,
    input wire logic rd_ready,
    output ddrps_pkg::ddrps_beat_t rd_beat
);
    ddrps_pkg::ddrps_core_t s_reg;
    ddrps_pkg::ddrps_core_t s_next;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [ddrps_pkg::FIFO_W-1:0] fifo_out_data;
    logic strobe_edge;
    logic preamble_seen;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe edge and preamble decode from the second and third sampled stages
    assign strobe_edge = (s_reg.dqs_s2 != s_reg.dqs_s3);
    assign preamble_seen = s_reg.seen_idle && (s_reg.dqs_s2 != ddrps_pkg::DQS_IDLE_LVL);
    // R2: load on chosen edge
    // The phase bit splits system edges into two alternating slots; pol picks one
    assign fifo_in_valid = s_reg.pend && (s_reg.phase == s_reg.pol);

    // Next-state logic
    always_comb
    begin
        s_next = s_reg;
        s_next.dqs_s1 = dqs_in;
        s_next.dqs_s2 = s_reg.dqs_s1;
        s_next.dqs_s3 = s_reg.dqs_s2;
        s_next.dq_s1 = dq_in;
        s_next.dq_s2 = s_reg.dq_s1;
        s_next.phase = !s_reg.phase;
        // Word leaves the hold stage only when the FIFO takes it
        if (fifo_in_valid && fifo_in_ready)
        begin
            s_next.pend = 1'b0;
        end
        unique case (s_reg.state)
            ddrps_pkg::ST_IDLE:
            begin
                // R3: fresh evaluation
                // Detector is rearmed; the old pol is kept until the preamble overwrites it, before any capture
                if (rd_start)
                begin
                    s_next.state = ddrps_pkg::ST_ARMED;
                    s_next.seen_idle = 1'b0;
                    s_next.ovf = 1'b0;
                    s_next.edges = ddrps_pkg::EDGES_RST;
                end
            end
            ddrps_pkg::ST_ARMED:
            begin
                // R6: preamble detector
                // Needs the terminated idle level first, then the driven low
                if (s_reg.dqs_s2 == ddrps_pkg::DQS_IDLE_LVL)
                begin
                    s_next.seen_idle = 1'b1;
                end
                else if (preamble_seen)
                begin
                    s_next.state = ddrps_pkg::ST_BURST;
                    // R7: detector sets polarity
                    s_next.pol = s_reg.phase;
                end
            end
            ddrps_pkg::ST_BURST:
            begin
                // R1: capture on strobe edge
                if (strobe_edge)
                begin
                    s_next.edges = s_reg.edges + 1'b1;
                    s_next.hold.data = s_reg.dq_s2;
                    s_next.hold.last = (s_reg.edges + 1'b1) == ddrps_pkg::BURST_EDGES;
                    s_next.pend = 1'b1;
                    // A word still waiting is overwritten; flag the loss
                    if (s_reg.pend && !(fifo_in_valid && fifo_in_ready))
                    begin
                        s_next.ovf = 1'b1;
                    end
                    if ((s_reg.edges + 1'b1) == ddrps_pkg::BURST_EDGES)
                    begin
                        s_next.state = ddrps_pkg::ST_DRAIN;
                    end
                end
            end
            ddrps_pkg::ST_DRAIN:
            begin
                // R8: hold polarity until transferred
                if (!s_next.pend)
                begin
                    s_next.state = ddrps_pkg::ST_IDLE;
                end
            end
            default:
            begin
                s_next.state = ddrps_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg.state <= ddrps_pkg::ST_IDLE;
            s_reg.dqs_s1 <= ddrps_pkg::DQS_IDLE_LVL;
            s_reg.dqs_s2 <= ddrps_pkg::DQS_IDLE_LVL;
            s_reg.dqs_s3 <= ddrps_pkg::DQS_IDLE_LVL;
            s_reg.dq_s1 <= ddrps_pkg::DQ_RST;
            s_reg.dq_s2 <= ddrps_pkg::DQ_RST;
            s_reg.seen_idle <= 1'b0;
            s_reg.phase <= ddrps_pkg::PHASE_RST;
            s_reg.pol <= ddrps_pkg::POL_RST;
            s_reg.edges <= ddrps_pkg::EDGES_RST;
            s_reg.pend <= 1'b0;
            s_reg.hold <= ddrps_pkg::BEAT_RST;
            s_reg.ovf <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Elastic store between capture and the consumer
    ddrps_fifo #(
        .W(ddrps_pkg::FIFO_W),
        .DEPTH(ddrps_pkg::FIFO_DEPTH),
        .AW(ddrps_pkg::FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(s_reg.hold),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(fifo_out_data)
    );

    // Outputs
    assign rd_beat = ddrps_pkg::ddrps_beat_t'(fifo_out_data);
    assign rd_busy = (s_reg.state != ddrps_pkg::ST_IDLE);
    assign pol_out = s_reg.pol;
    assign overflow = s_reg.ovf;

    ////////////////////////////////////////////////////////////////////////////
    // Checks beside the logic
    rearm_clears_a: assert property ( // R3
        @(posedge clk) disable iff (!rst_n)
        (s_reg.state == ddrps_pkg::ST_IDLE) && rd_start
        |=> (s_reg.state == ddrps_pkg::ST_ARMED) && !s_reg.seen_idle && !s_reg.ovf)
        else $error("read start did not rearm the detector");

    preamble_detect_a: assert property ( // R6
        @(posedge clk) disable iff (!rst_n)
        (s_reg.state == ddrps_pkg::ST_ARMED) && s_reg.seen_idle && !s_reg.dqs_s2
        |=> (s_reg.state == ddrps_pkg::ST_BURST))
        else $error("preamble low not detected");

    no_early_burst_a: assert property ( // R6
        @(posedge clk) disable iff (!rst_n)
        (s_reg.state == ddrps_pkg::ST_ARMED) && !s_reg.seen_idle
        |=> (s_reg.state != ddrps_pkg::ST_BURST))
        else $error("burst entered without idle level seen");

    pol_from_det_a: assert property ( // R7
        @(posedge clk) disable iff (!rst_n)
        (s_reg.state == ddrps_pkg::ST_ARMED) ##1 (s_reg.state == ddrps_pkg::ST_BURST)
        |-> (s_reg.pol == $past(s_reg.phase)))
        else $error("polarity not taken from detector phase");

    pol_hold_a: assert property ( // R8
        @(posedge clk) disable iff (!rst_n)
        (s_reg.state inside {ddrps_pkg::ST_BURST, ddrps_pkg::ST_DRAIN})
        ##1 (s_reg.state inside {ddrps_pkg::ST_BURST, ddrps_pkg::ST_DRAIN})
        |-> $stable(s_reg.pol))
        else $error("polarity changed inside a read");

    load_slot_a: assert property ( // R2
        @(posedge clk) disable iff (!rst_n)
        s_reg.pend && fifo_in_ready && (s_reg.phase != s_reg.pol)
        |=> s_reg.pend)
        else $error("word loaded on the wrong system edge");

    edge_capture_a: assert property ( // R1
        @(posedge clk) disable iff (!rst_n)
        (s_reg.state == ddrps_pkg::ST_BURST) && strobe_edge
        |=> s_reg.pend && (s_reg.hold.data == $past(s_reg.dq_s2)))
        else $error("strobe edge did not capture data");

    // A fresh strobe edge refills the hold stage, so only edge-free windows are bounded
    transfer_bound_a: assert property ( // R1
        @(posedge clk) disable iff (!rst_n)
        s_reg.pend && fifo_in_ready && !strobe_edge ##1 fifo_in_ready && !strobe_edge
        |-> ##[0:1] !s_reg.pend)
        else $error("pending word not transferred within two edges");

    last_marker_a: assert property ( // R1
        @(posedge clk) disable iff (!rst_n)
        (s_reg.state == ddrps_pkg::ST_BURST) && strobe_edge
        && (s_reg.edges == (ddrps_pkg::BURST_EDGES - 1'b1))
        |=> s_reg.hold.last && (s_reg.state == ddrps_pkg::ST_DRAIN))
        else $error("final strobe edge did not mark the last word");

    drain_exit_a: assert property ( // R8
        @(posedge clk) disable iff (!rst_n)
        (s_reg.state == ddrps_pkg::ST_DRAIN) && fifo_in_valid && fifo_in_ready
        |=> (s_reg.state == ddrps_pkg::ST_IDLE))
        else $error("read did not end once its last word moved on");
endmodule

// [tb/ddrps_mem_model.sv]
// Behavioural memory that drives the read strobe and data for one burst per go pulse
`timescale 1ns/1ps
module ddrps_mem_model (
    input wire logic go,
    input wire logic late,
    input wire logic [ddrps_pkg::DQ_W-1:0] base,
    output logic dqs,
    output logic [ddrps_pkg::DQ_W-1:0] dq
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle: strobe released, termination holds it at its idle level
    initial
    begin
        dqs = ddrps_pkg::DQS_IDLE_LVL;
        dq = 8'h5a;
    end

    // Off-grid delays keep strobe edges away from clk edges; late shifts by one cycle
    always @(posedge go)
    begin
        dqs = ddrps_pkg::DQS_IDLE_LVL;
        #(late ? 430 : 330);
        dqs = 1'b0;
        #800;
        for (int k = 0; k < 8; k++)
        begin
            dq = base + 8'(k);
            #100;
            dqs = ~dqs;
            #300;
        end
        // Released data no longer shows the last word
        dq = ~dq;
        #100;
        dqs = ddrps_pkg::DQS_IDLE_LVL;
    end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the read strobe synchroniser
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd_start = 1'b0;
    logic rd_ready = 1'b0;
    logic go = 1'b0;
    logic late = 1'b0;
    logic [ddrps_pkg::DQ_W-1:0] base = 8'h00;
    logic dqs;
    logic [ddrps_pkg::DQ_W-1:0] dq;
    logic rd_busy;
    logic pol_out;
    logic overflow;
    logic rd_valid;
    logic pol_a;
    ddrps_pkg::ddrps_beat_t rd_beat;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and cycle count; reset has a single driver in the sequencer below
    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    ddrps_mem_model mem_u (.go(go), .late(late), .base(base), .dqs(dqs), .dq(dq));

    ddrps_sync dut_u (.clk(clk), .rst_n(rst_n), .rd_start(rd_start), .dqs_in(dqs),
        .dq_in(dq), .rd_busy(rd_busy), .pol_out(pol_out), .overflow(overflow),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_beat(rd_beat));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared compare and closing
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Bounded wait for the read to finish
    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge clk);
        while (rd_busy !== 1'b0 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        check({8'h00, rd_busy}, 9'h000);
    endtask

    // Start a read on an even cycle so preamble timing alone sets the polarity
    task automatic launch(input logic [7:0] b, input logic l);
        @(posedge clk);
        base <= b;
        late <= l;
        @(negedge clk);
        while (cyc[0])
            @(negedge clk);
        @(posedge clk);
        rd_start <= 1'b1;
        go <= 1'b1;
        @(posedge clk);
        rd_start <= 1'b0;
        go <= 1'b0;
    endtask

    // Pop one word; rd_ready stays up for exactly one edge
    task automatic pop(input logic [7:0] d, input logic last);
        int n;
        n = 0;
        @(negedge clk);
        while (rd_valid !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        check({8'h00, rd_valid}, 9'h001);
        check(rd_beat, {last, d});
        @(posedge clk);
        rd_ready <= 1'b1;
        @(posedge clk);
        rd_ready <= 1'b0;
    endtask

    // Eight words in strobe order, polarity unchanged across the burst
    task automatic burst(input logic [7:0] b);
        logic p;
        for (int k = 0; k < 8; k++)
        begin
            pop(b + 8'(k), k == 7);
            if (k == 0)
                p = pol_out;
            if (k == 7)
                check({8'h00, pol_out}, {8'h00, p});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_basic();
        launch(8'h10, 1'b0);
        burst(8'h10);
        pol_a = pol_out;
        wait_idle();
        check({8'h00, overflow}, 9'h000);
    endtask

    // Preamble one cycle later must flip the chosen polarity, then flip back
    task automatic t_repol();
        launch(8'h40, 1'b1);
        burst(8'h40);
        check({8'h00, pol_out}, {8'h00, ~pol_a});
        wait_idle();
        launch(8'h50, 1'b0);
        burst(8'h50);
        check({8'h00, pol_out}, {8'h00, pol_a});
        wait_idle();
    endtask

    // Consumer stalls: 16 words fill the FIFO, the third read overruns
    task automatic t_overflow();
        launch(8'h80, 1'b0);
        wait_idle();
        launch(8'h90, 1'b0);
        wait_idle();
        launch(8'ha0, 1'b0);
        repeat (60) @(negedge clk);
        check({8'h00, overflow}, 9'h001);
        burst(8'h80);
        burst(8'h90);
        rst_n <= 1'b0;
        repeat (3) @(negedge clk);
        check({7'h00, overflow, rd_busy}, 9'h000);
        @(posedge clk);
        rst_n <= 1'b1;
        // After release the block must sit idle with the reset polarity
        @(posedge clk);
        @(negedge clk);
        check({6'h00, rd_busy, rd_valid, pol_out}, 9'h000);
    endtask

    initial
    begin
        // Reset held five cycles, released on a rising edge
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_basic();
        t_repol();
        t_overflow();
        finish_test();
    end

    // Watchdog well past the expected run of a few hundred cycles
    initial
    begin
        #200000;
        err_total++;
        finish_test();
    end
endmodule
